// file: rtl/status_flags_and_table_read.sv
// Status flags and table-read registers behind an AXI4-Lite slave
//
// Functional notes
// RQ1: Table pointer addresses program memory for reads
// RQ2: Software loads pointer before any table read
// RQ3: Upper fetched byte latches into high register
// RQ4: Lower fetched byte goes to instruction destination
// RQ5: Status bits: sc cz wdx pdn ovf zero nib c
// RQ6: Status writes may change all but two flags
// RQ7: Data writes never touch expiry or powerdown
// RQ8: Expiry flag cleared by reset/clear/halt, set timeout
// RQ9: Powerdown flag cleared by reset/clear, set halt
// RQ10: Carry on add carry or subtract no borrow
// RQ11: Rotate through carry loads and shifts carry
// RQ12: Nibble carry from low nibble, same sense
// RQ13: Zero flag set on zero result
// RQ14: Overflow on mismatched carries at top bit
// RQ15: Signed compare is overflow xor result top
// RQ16: Subtract sets chained zero equal to zero
// RQ17: Subtract-borrow ANDs chained zero with zero
// RQ18: Other operations leave chained zero alone
// RQ19: Calls and interrupts do not save status
// RQ20: Unaffected flags hold; commit with result
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module status_flags_and_table_read (
    input wire logic ref_clk, // System clock, 10 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [15:0] prog_word, // Program word at pointer
    output logic [7:0] table_pointer, // Program memory address
    output logic [7:0] table_low_byte // Low byte to destination
);

    // Flag computation for one operation
    function automatic flag_pkg::op_res_type alu_eval(
        input flag_pkg::alu_op_type op,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] fl
    );
        logic [8:0] sum;
        logic [4:0] low;
        logic [7:0] bb;
        logic cin;
        logic c7;
        logic ov;
        flag_pkg::op_res_type r;
        sum = 9'h000;
        low = 5'h00;
        bb = b;
        cin = 1'b0;
        c7 = 1'b0;
        ov = 1'b0;
        r.result = a;
        r.flags = fl;
        unique case (op)
            flag_pkg::op_add, flag_pkg::op_addc, flag_pkg::op_sub,
            flag_pkg::op_sbc: begin
                // Subtract as add of complement: carry means no borrow
                bb = (op == flag_pkg::op_sub || op == flag_pkg::op_sbc) ?
                    ~b : b;
                // Plain subtract forces carry-in; chained forms use C
                cin = (op == flag_pkg::op_sub) ? 1'b1 :
                    (op == flag_pkg::op_add) ? 1'b0 :
                    fl[flag_pkg::carry_bit];
                sum = {1'b0, a} + {1'b0, bb} + {flag_pkg::byte_zero, cin};
                low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} +
                    {flag_pkg::nib_zero, cin};
                // Carry into the top bit recovered from the sum bit
                c7 = a[7] ^ bb[7] ^ sum[7];
                ov = c7 ^ sum[8];
                r.result = sum[7:0];
                r.flags[flag_pkg::carry_bit] = sum[8]; // RQ10
                r.flags[flag_pkg::nibble_bit] = low[4]; // RQ12
                r.flags[flag_pkg::ovf_bit] = ov; // RQ14
                // Uses the new overflow, not the stored one
                r.flags[flag_pkg::sc_bit] = ov ^ sum[7]; // RQ15
            end
            flag_pkg::op_and: r.result = a & b;
            flag_pkg::op_or: r.result = a | b;
            flag_pkg::op_xor: r.result = a ^ b;
            flag_pkg::op_rlc: begin
                r.result = {a[6:0], fl[flag_pkg::carry_bit]}; // RQ11
                r.flags[flag_pkg::carry_bit] = a[7]; // RQ11
            end
            flag_pkg::op_rrc: begin
                r.result = {fl[flag_pkg::carry_bit], a[7:1]}; // RQ11
                r.flags[flag_pkg::carry_bit] = a[0]; // RQ11
            end
            default: r.result = a;
        endcase
        // Zero for arithmetic and logic ops; rotates leave it
        if (op inside {flag_pkg::op_add, flag_pkg::op_addc,
            flag_pkg::op_sub, flag_pkg::op_sbc, flag_pkg::op_and,
            flag_pkg::op_or, flag_pkg::op_xor}) begin
            r.flags[flag_pkg::zero_bit] =
                (r.result == flag_pkg::byte_zero); // RQ13
        end
        if (op == flag_pkg::op_sub) begin
            r.flags[flag_pkg::cz_bit] = r.flags[flag_pkg::zero_bit]; // RQ16
        end else if (op == flag_pkg::op_sbc) begin
            r.flags[flag_pkg::cz_bit] = fl[flag_pkg::cz_bit] &
                r.flags[flag_pkg::zero_bit]; // RQ17
        end
        // Other ops: chained zero and untouched flags hold RQ18 RQ20
        return r;
    endfunction

    // Byte-lane merge used by the flag, pointer and operand writes
    function automatic logic [7:0] lane_merge(
        input logic [7:0] old,
        input logic [7:0] nw,
        input logic en
    );
        return en ? nw : old;
    endfunction

    // Byte register placed in bits 7:0 of a bus word, upper bits zero
    function automatic logic [31:0] byte_word(
        input logic [7:0] v
    );
        return {flag_pkg::word_zero[31:8], v};
    endfunction

    // Engine and bus slave state, each with its next value
    logic [7:0] flags_q, flags_d;
    logic [7:0] tptr_q, tptr_d;
    logic [7:0] thigh_q, thigh_d;
    logic [7:0] tlow_q, tlow_d;
    logic [7:0] result_q, result_d;
    flag_pkg::op_req_type req_q, req_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    flag_pkg::op_res_type res;

    // Write channel: take address and data in either order
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (awaddr_q == flag_pkg::flags_addr ||
                awaddr_q == flag_pkg::tbl_ptr_addr ||
                awaddr_q == flag_pkg::op_ctrl_addr) ?
                flag_pkg::resp_okay : flag_pkg::resp_slverr;
        end
        // Hold ready low once a beat is held, until response is sent
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= flag_pkg::word_zero;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= flag_pkg::resp_okay;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
        end
    end

    logic wr_fire;
    // Commit point: both beats held and no answer pending
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // Register file and flag engine; ops run one cycle after the write
    always_comb begin
        flags_d = flags_q;
        tptr_d = tptr_q;
        thigh_d = thigh_q;
        tlow_d = tlow_q;
        result_d = result_q;
        req_d = req_q;
        req_d.go = 1'b0;
        res = alu_eval(req_q.op, req_q.a, req_q.b, flags_q);
        if (req_q.go) begin
            unique case (req_q.op)
                flag_pkg::op_watchdog_clear_instr: begin
                    flags_d[flag_pkg::wdx_bit] = 1'b0; // RQ8
                    flags_d[flag_pkg::pdn_bit] = 1'b0; // RQ9
                end
                flag_pkg::op_halt: begin
                    flags_d[flag_pkg::wdx_bit] = 1'b0; // RQ8
                    flags_d[flag_pkg::pdn_bit] = 1'b1; // RQ9
                end
                flag_pkg::op_wdt_expire: begin
                    flags_d[flag_pkg::wdx_bit] = 1'b1; // RQ8
                end
                flag_pkg::op_tbl_read: begin
                    // Word at the pointer, taken at the edge after the write commit
                    thigh_d = prog_word[15:8]; // RQ3
                    tlow_d = prog_word[7:0]; // RQ4
                end
                flag_pkg::op_none: begin
                end
                flag_pkg::op_add, flag_pkg::op_addc, flag_pkg::op_sub,
                flag_pkg::op_sbc, flag_pkg::op_and, flag_pkg::op_or,
                flag_pkg::op_xor, flag_pkg::op_rlc, flag_pkg::op_rrc: begin
                    // Result and flags commit together RQ20
                    result_d = res.result;
                    flags_d = res.flags;
                end
                default: begin
                    // Spare codes act as no operation
                end
            endcase
        end
        if (wr_fire) begin
            unique case (awaddr_q)
                flag_pkg::flags_addr: begin
                    // Expiry and powerdown stay read-only RQ6 RQ7
                    // A cleared byte strobe keeps the old value
                    flags_d = (lane_merge(flags_q, wdata_q[7:0],
                        wstrb_q[0]) & flag_pkg::flags_wr_mask) |
                        (flags_d & ~flag_pkg::flags_wr_mask);
                end
                flag_pkg::tbl_ptr_addr: begin
                    tptr_d = lane_merge(tptr_q, wdata_q[7:0],
                        wstrb_q[0]); // RQ2
                end
                flag_pkg::op_ctrl_addr: begin
                    req_d.op = flag_pkg::alu_op_type'(
                        wdata_q[flag_pkg::op_msb:flag_pkg::op_lsb]);
                    req_d.a = lane_merge(req_q.a,
                        wdata_q[flag_pkg::a_lsb +: 8], wstrb_q[1]);
                    req_d.b = lane_merge(req_q.b,
                        wdata_q[flag_pkg::b_lsb +: 8], wstrb_q[2]);
                    req_d.go = wdata_q[flag_pkg::go_bit] && wstrb_q[3];
                end
                default: begin
                end
            endcase
        end
    end

    // Power-up clears every flag, expiry and powerdown included
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= flag_pkg::flags_reset; // RQ8 RQ9
            tptr_q <= flag_pkg::byte_zero;
            thigh_q <= flag_pkg::byte_zero;
            tlow_q <= flag_pkg::byte_zero;
            result_q <= flag_pkg::byte_zero;
            req_q <= '0;
        end else begin
            flags_q <= flags_d;
            tptr_q <= tptr_d;
            thigh_q <= thigh_d;
            tlow_q <= tlow_d;
            result_q <= result_d;
            req_q <= req_d;
        end
    end

    // Read channel: one read at a time, answer one cycle after take
    // Address decoded at the take edge; data frozen until rready
    always_comb begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = flag_pkg::resp_okay;
            unique case (s_axi_araddr)
                flag_pkg::flags_addr: rdata_d = byte_word(flags_q); // RQ5
                flag_pkg::tbl_ptr_addr: rdata_d = byte_word(tptr_q);
                flag_pkg::tbl_high_addr: rdata_d = byte_word(thigh_q); // RQ3
                flag_pkg::op_ctrl_addr: begin
                    // Go bit reads back as zero: it is a strobe
                    rdata_d = {1'b0, flag_pkg::seven_zero, req_q.b,
                        req_q.a, result_q};
                end
                default: begin
                    rdata_d = flag_pkg::word_zero;
                    rresp_d = flag_pkg::resp_slverr;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end else if (!rvalid_q) begin
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= flag_pkg::word_zero;
            rresp_q <= flag_pkg::resp_okay;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Status is not stacked; calls and interrupts leave it alone RQ19
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign table_pointer = tptr_q; // RQ1
    assign table_low_byte = tlow_q; // RQ4

endmodule

// file: rtl/flag_pkg.sv
// Package: status byte layout, register map and operation codes
package flag_pkg;
    // Register byte addresses on the bus
    localparam logic [3:0] flags_addr = 4'h0;
    localparam logic [3:0] tbl_ptr_addr = 4'h4;
    localparam logic [3:0] tbl_high_addr = 4'h8;
    localparam logic [3:0] op_ctrl_addr = 4'hC;

    // Status byte bit positions
    localparam int carry_bit = 0;
    localparam int nibble_bit = 1;
    localparam int zero_bit = 2;
    localparam int ovf_bit = 3;
    localparam int pdn_bit = 4;
    localparam int wdx_bit = 5;
    localparam int cz_bit = 6;
    localparam int sc_bit = 7;

    // Software may only change these status bits
    localparam logic [7:0] flags_wr_mask = 8'hCF;
    localparam logic [7:0] flags_reset = 8'h00;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [3:0] nib_zero = 4'h0;
    localparam logic [6:0] seven_zero = 7'h00;
    localparam logic [31:0] word_zero = 32'h0000_0000;

    // Control register field positions
    localparam int op_lsb = 0;
    localparam int op_msb = 3;
    localparam int go_bit = 31;
    localparam int a_lsb = 8;
    localparam int b_lsb = 16;

    // Bus responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [3:0] {
        op_none, op_add, op_addc, op_sub, op_sbc, op_and, op_or, op_xor,
        op_rlc, op_rrc, op_watchdog_clear_instr, op_halt, op_wdt_expire, op_tbl_read
    } alu_op_type;

    // Operation request from the core
    typedef struct packed {
        logic go;
        alu_op_type op;
        logic [7:0] a;
        logic [7:0] b;
    } op_req_type;

    // Flag-side result of an operation
    typedef struct packed {
        logic [7:0] result;
        logic [7:0] flags;
    } op_res_type;
endpackage

// file: verif/flags_port_asserts.sv
// Checker: bus answers and table-read outputs
`timescale 1ns/10ps
module flags_port_asserts (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic s_axi_awvalid, // Bus
    input wire logic s_axi_awready, // Bus
    input wire logic s_axi_wvalid, // Bus
    input wire logic s_axi_wready, // Bus
    input wire logic [1:0] s_axi_bresp, // Bus
    input wire logic s_axi_bvalid, // Bus
    input wire logic s_axi_bready, // Bus
    input wire logic s_axi_arvalid, // Bus
    input wire logic s_axi_arready, // Bus
    input wire logic [31:0] s_axi_rdata, // Bus
    input wire logic s_axi_rvalid, // Bus
    input wire logic s_axi_rready, // Bus
    input wire logic [15:0] prog_word, // Memory word
    input wire logic [7:0] table_pointer, // Pointer
    input wire logic [7:0] table_low_byte // Low byte
);
    // One clock domain, so one default for all checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Bus answers come at fixed distances and hold
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer missing");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_aw_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
    // Byte registers fill bits 7:0 and the control register bits 23:0; top byte always reads zero
    chk_upper_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:24] == 8'h00) else $error("top byte set");
    // Pointer moves only with a write commit
    chk_ptr_change: assert property (!$stable(table_pointer)
        |-> $rose(s_axi_bvalid)) else $error("pointer moved alone");
    // Low byte comes straight from the fetched word
    chk_low_byte: assert property (!$stable(table_low_byte)
        |-> {8'h00, table_low_byte} == ($past(prog_word) & 16'h00FF))
        else $error("low byte not from word");
    cover property (s_axi_bvalid && s_axi_bresp == flag_pkg::resp_slverr);
    cover property (!$stable(table_low_byte));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind status_flags_and_table_read flags_port_asserts i_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prog_word(prog_word),
    .table_pointer(table_pointer), .table_low_byte(table_low_byte)
);

// file: verif/status_flags_and_table_read_bench.sv
// Bench: flag operation table, then table-read, bus and reset cases
`timescale 1ns/10ps
module status_flags_and_table_read_bench;
    typedef struct packed {
        logic [7:0] pre; // Status written first
        logic [3:0] op; // Operation code
        logic [7:0] a; // First operand
        logic [7:0] b; // Second operand
        logic [7:0] fl; // Status expected after
        logic [7:0] res; // Result expected
    } row_type;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [15:0] prog_word = 16'h0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, d;
    logic [7:0] table_pointer, table_low_byte, p;
    int miscompares = 0, n_compared = 0;
    // Sub and borrow rows chain the zero flag; watchdog rows run last
    row_type rows [0:19] = '{
        '{8'h40,4'h1,8'h7F,8'h01,8'h4A,8'h80},
        '{8'h00,4'h1,8'hFF,8'h01,8'h07,8'h00},
        '{8'h01,4'h2,8'h10,8'h20,8'h00,8'h31},
        '{8'h00,4'h3,8'h05,8'h05,8'h47,8'h00},
        '{8'h40,4'h3,8'h80,8'h01,8'h89,8'h7F},
        '{8'h41,4'h4,8'h03,8'h03,8'h47,8'h00},
        '{8'h01,4'h4,8'h03,8'h03,8'h07,8'h00},
        '{8'h40,4'h4,8'h03,8'h02,8'h47,8'h00},
        '{8'h8B,4'h5,8'hF0,8'h0F,8'h8F,8'h00},
        '{8'h04,4'h6,8'h12,8'h01,8'h00,8'h13},
        '{8'h00,4'h7,8'hAA,8'hAA,8'h04,8'h00},
        '{8'h44,4'h8,8'h81,8'h00,8'h45,8'h02},
        '{8'h01,4'h9,8'h01,8'h00,8'h01,8'h80},
        '{8'hCF,4'h0,8'h00,8'h00,8'hCF,8'h00},
        '{8'hCF,4'hE,8'h00,8'h00,8'hCF,8'h00},
        '{8'h00,4'hB,8'h00,8'h00,8'h10,8'h00},
        '{8'h00,4'hC,8'h00,8'h00,8'h30,8'h00},
        '{8'hCF,4'hB,8'h00,8'h00,8'hDF,8'h00},
        '{8'h00,4'hC,8'h00,8'h00,8'h30,8'h00},
        '{8'h00,4'hA,8'h00,8'h00,8'h00,8'h00}};

    status_flags_and_table_read i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .prog_word(prog_word), .table_pointer(table_pointer),
        .table_low_byte(table_low_byte)
    );

    // Clock, 100 ns period
    always #50 ref_clk = ~ref_clk;
    // Program memory: word derived from address, one cycle late
    always @(posedge ref_clk) begin
        prog_word <= {~table_pointer, table_pointer ^ 8'h5A};
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] ad, input logic [31:0] dt,
                      output logic [1:0] r);
        int n;
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            miscompares++;
            finish_test();
        end
        @(posedge ref_clk);
    endtask

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [3:0] ad, output logic [31:0] dt,
                      output logic [1:0] r);
        int n;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        dt = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            miscompares++;
            finish_test();
        end
        @(posedge ref_clk);
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    // Main sequence
    initial begin
        do_reset();
        rd(4'h0, d, rs);
        chk(d, 32'h0000_0000);
        chk({24'h0, table_pointer}, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 20; i++) begin
            wr(4'h0, {24'h0, rows[i].pre}, rs);
            wr(4'hC, {1'b1, 7'h00, rows[i].b, rows[i].a, 4'h0, rows[i].op},
               rs);
            rd(4'h0, d, rs);
            chk(d, {24'h0, rows[i].fl});
            if (rows[i].op inside {[4'h1:4'h9]}) begin
                rd(4'hC, d, rs);
                chk(d, {8'h00, rows[i].b, rows[i].a, rows[i].res});
            end
        end
        $display("operation table done");
        // Two table reads, the second at the top pointer value
        for (int k = 0; k < 2; k++) begin
            p = k ? 8'hFF : 8'h3C;
            wr(4'h4, {24'h0, p}, rs);
            wr(4'hC, 32'h8000_000D, rs);
            rd(4'h8, d, rs);
            chk(d, {24'h0, ~p});
            chk({24'h0, table_low_byte}, {24'h0, p ^ 8'h5A});
            chk({24'h0, table_pointer}, {24'h0, p});
        end
        wr(4'h8, 32'h0000_0055, rs);
        chk({30'h0, rs}, {30'h0, flag_pkg::resp_slverr});
        rd(4'h8, d, rs);
        chk(d, 32'h0000_0000);
        rd(4'h2, d, rs);
        chk({d[29:0], rs}, {30'h0, flag_pkg::resp_slverr});
        wr(4'h0, 32'h0000_00FF, rs);
        chk({30'h0, rs}, {30'h0, flag_pkg::resp_okay});
        rd(4'h0, d, rs);
        chk({30'h0, rs}, {30'h0, flag_pkg::resp_okay});
        chk(d, 32'h0000_00CF);
        $display("table and bus test done");
        // Halt, then reset in mid-run must clear powerdown and the other set flags
        wr(4'hC, 32'h8000_000B, rs);
        rd(4'h0, d, rs);
        chk(d, 32'h0000_00DF);
        do_reset();
        rd(4'h0, d, rs);
        chk(d, 32'h0000_0000);
        chk({24'h0, table_pointer}, 32'h0000_0000);
        chk({24'h0, table_low_byte}, 32'h0000_0000);
        $display("second reset test done");
        finish_test();
    end
endmodule
